/* File: rtl/ctn_trap_ctrl.sv */
// trap, debug save/restore and nested interrupt control
//
// Contract
// - handler active flag is status bit 6, set on every exception entry.
// - illegal opcode: bits 10..5 all ones, bits 26..23 at least 7, bit 16 zero.
// - opcode trap saves pc and status to debug copies, sets three flags, jumps 60h.
// - debug trap always taken, same save and flags, jumps 60h, enters debug mode.
// - debug return reloads pc and status from debug copies and continues there.
// - higher level request preempts service; lower level request stays pending.
// - maskable requests are accepted only while the block flag is clear.
// - each source has a 3-bit level, eight levels, level 0 highest.
// - after reset every source is masked and at level 7.
// - pending or suspended service resumes only after interrupt return.
// - no maskable acceptance while the non-maskable routine runs.
// - no acceptance between a sampling-blocking instruction and the next one.
// - blocking: unmask, mask, psw load, control register access, protect store; the code also blocks on the serial kind.
// - interrupt return with handler flag set reloads from exception copies.
`timescale 1ns/1ps
`default_nettype none
`include "ctn_regs.svh"

module ctn_trap_ctrl (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  // instruction leaving the pipeline
  input  wire logic                INSTR_VALID,
  input  wire logic [31:0]         INSTR_WORD,
  input  wire ctn_pkg::ctn_kind_t  INSTR_KIND,
  input  wire ctn_pkg::ctn_sreg_t  INSTR_SREG,
  input  wire logic [31:0]         INSTR_WDATA,
  input  wire logic [31:0]         RET_PC,
  // request sources
  input  wire logic [7:0]          IRQ_REQ,
  input  wire logic                NMI_REQ,
  // control register port
  input  wire logic                CTRL_WR,
  input  wire logic                CTRL_RD,
  input  wire logic [2:0]          CTRL_IDX,
  input  wire logic [3:0]          CTRL_WDATA,
  output logic      [3:0]          CTRL_RDATA,
  // redirect to the fetch stage
  output logic                     REDIRECT,
  output logic      [31:0]         REDIRECT_PC,
  output logic                     IRQ_ACK,
  output logic      [2:0]          IRQ_ACK_ID,
  output logic                     NMI_ACK,
  // architectural state
  output logic      [31:0]         PROGRAM_STATUS_WORD,
  output logic      [31:0]         DEBUG_SAVED_PC,
  output logic      [31:0]         DEBUG_SAVED_STATUS,
  output logic      [31:0]         EXCEPTION_SAVED_PC,
  output logic      [31:0]         EXCEPTION_SAVED_STATUS,
  output logic      [7:0]          IN_SERVICE_PRIORITY_REG,
  output logic                     DEBUG_MODE
);
  import ctn_pkg::*;

  // ********************************************************
  // decode helpers
  // ********************************************************

  // illegal opcode pattern
  function automatic logic is_illegal(input logic [31:0] w);
    is_illegal = (w[10:5] == `CTN_ILG_OPC) && (w[26:23] >= `CTN_ILG_SUB_MIN) && !w[16];
  endfunction

  // instructions after which sampling pauses for one instruction
  function automatic logic is_blocking(input ctn_kind_t k, input ctn_sreg_t s);
    case (k)
      CTN_K_EI, CTN_K_DI, CTN_K_IRQREG, CTN_K_PROTECT_COMMAND_REG, CTN_K_SERIAL: is_blocking = 1'b1;
      CTN_K_LOAD_SYSREG_INSTR:                                                  is_blocking = (s == CTN_S_PSW);
      default:                                                     is_blocking = 1'b0;
    endcase
  endfunction

  // highest in-service level, 8 when idle
  function automatic logic [3:0] top_level(input logic [7:0] v);
    top_level = `CTN_NO_LEVEL;
    for (int i = `CTN_NUM_SRC - 1; i >= 0; i--)
      if (v[i])
        top_level = 4'(i);
  endfunction

  // ********************************************************
  // state
  // ********************************************************

  ctn_mode_t   mode;
  logic [7:0]  irq_pend;
  logic        nmi_pend;
  logic        block;
  logic [2:0]  ack_lvl;
  logic [31:0] entries;
  logic        illegal;
  logic        dbg_entry;
  logic        dbg_ret;
  logic        interrupt_return_instr;
  logic        sample_ok;
  logic        take_nmi;
  logic        take_irq;
  logic        sel_found;
  logic [2:0]  sel_idx;
  logic [2:0]  sel_lvl;
  logic [3:0]  cur_lvl;
  logic [31:0] entry_psw;

  ctn_ctrl_mem u_ctrl (
    .clk     (CLK),
    .rst     (RST),
    .wr      (CTRL_WR),
    .rd      (CTRL_RD),
    .idx     (CTRL_IDX),
    .wdata   (CTRL_WDATA),
    .rdata   (CTRL_RDATA),
    .entries (entries)
  );

  // ********************************************************
  // arbitration
  // ********************************************************

  // lowest level wins; scanning upward keeps the first index on ties
  always_comb
  begin
    sel_found = 1'b0;
    sel_idx   = 3'h0;
    sel_lvl   = `CTN_PRIO_LOWEST;
    for (int i = 0; i < `CTN_NUM_SRC; i++)
      if (irq_pend[i] && !entries[i*4 + `CTN_CTL_MASK] &&
          (!sel_found || entries[i*4 +: 3] < sel_lvl))
      begin
        sel_found = 1'b1;
        sel_idx   = 3'(i);
        sel_lvl   = entries[i*4 +: 3];
      end
  end

  // events of this cycle; traps outrank every interrupt
  always_comb
  begin
    cur_lvl   = top_level(IN_SERVICE_PRIORITY_REG);
    illegal   = INSTR_VALID && (INSTR_KIND == CTN_K_OTHER) && is_illegal(INSTR_WORD);
    dbg_entry = illegal || (INSTR_VALID && INSTR_KIND == CTN_K_DEBUG_TRAP_INSTRUCTION);
    dbg_ret   = INSTR_VALID && (INSTR_KIND == CTN_K_DEBUG_RETURN_INSTR);
    interrupt_return_instr      = INSTR_VALID && (INSTR_KIND == CTN_K_INTERRUPT_RETURN_INSTR);
    // the retire right after a blocking one is not a sampling point either
    sample_ok = INSTR_VALID && !block && !is_blocking(INSTR_KIND, INSTR_SREG) &&
                !dbg_entry && !dbg_ret && !interrupt_return_instr && (mode == CTN_RUN);
    take_nmi  = sample_ok && nmi_pend && !PROGRAM_STATUS_WORD[`CTN_PSW_NP];
    // only a strictly higher level than the one in service gets in
    take_irq  = sample_ok && !take_nmi && sel_found && !PROGRAM_STATUS_WORD[`CTN_PSW_ID] &&
                !PROGRAM_STATUS_WORD[`CTN_PSW_NP] && ({1'b0, sel_lvl} < cur_lvl);
    entry_psw = PROGRAM_STATUS_WORD;
    entry_psw[`CTN_PSW_NP] = 1'b1;
    entry_psw[`CTN_PSW_EP] = 1'b1;
    entry_psw[`CTN_PSW_ID] = 1'b1;
  end

  // ********************************************************
  // sequential logic
  // ********************************************************

  // sampling gap after a blocking instruction, closed by the next retire
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      block <= 1'b0;
    else if (INSTR_VALID)
      block <= is_blocking(INSTR_KIND, INSTR_SREG);
  end

  // pending requests; a new edge beats the clear of acceptance
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      irq_pend <= 8'h00;
      nmi_pend <= 1'b0;
    end
    else
    begin
      irq_pend <= (irq_pend & ~(take_irq ? (8'h01 << sel_idx) : 8'h00)) | IRQ_REQ;
      nmi_pend <= (nmi_pend && !take_nmi) || NMI_REQ;
    end
  end

  // in-service levels; return from a maskable routine frees the top one
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      IN_SERVICE_PRIORITY_REG    <= 8'h00;
      ack_lvl <= 3'h0;
    end
    else if (take_irq)
    begin
      IN_SERVICE_PRIORITY_REG    <= IN_SERVICE_PRIORITY_REG | (8'h01 << sel_lvl);
      ack_lvl <= sel_lvl;
    end
    else if (interrupt_return_instr && !PROGRAM_STATUS_WORD[`CTN_PSW_NP] && cur_lvl != `CTN_NO_LEVEL)
      IN_SERVICE_PRIORITY_REG <= IN_SERVICE_PRIORITY_REG & ~(8'h01 << cur_lvl[2:0]);
  end

  // run or debug monitor
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      mode <= CTN_RUN;
    else
    begin
      case (mode)
        CTN_RUN:   if (dbg_entry) mode <= CTN_DEBUG;
        CTN_DEBUG: if (dbg_ret) mode <= CTN_RUN;
        default:   mode <= CTN_RUN;
      endcase
    end
  end

  // status word and save copies
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PROGRAM_STATUS_WORD   <= `CTN_PSW_RESET;
      DEBUG_SAVED_PC  <= 32'h00000000;
      DEBUG_SAVED_STATUS <= 32'h00000000;
      EXCEPTION_SAVED_PC  <= 32'h00000000;
      EXCEPTION_SAVED_STATUS <= 32'h00000000;
    end
    else if (dbg_entry)
    begin
      DEBUG_SAVED_PC  <= RET_PC;
      DEBUG_SAVED_STATUS <= PROGRAM_STATUS_WORD;
      PROGRAM_STATUS_WORD   <= entry_psw;
    end
    else if (dbg_ret)
      PROGRAM_STATUS_WORD <= DEBUG_SAVED_STATUS;
    else if (interrupt_return_instr)
      PROGRAM_STATUS_WORD <= EXCEPTION_SAVED_STATUS;
    else if (take_nmi || take_irq)
    begin
      // a nested entry overwrites these copies; software keeps its own
      EXCEPTION_SAVED_PC  <= RET_PC;
      EXCEPTION_SAVED_STATUS <= PROGRAM_STATUS_WORD;
      PROGRAM_STATUS_WORD   <= take_nmi ? entry_psw : (entry_psw & ~(32'h1 << `CTN_PSW_NP));
    end
    else if (INSTR_VALID)
    begin
      case (INSTR_KIND)
        CTN_K_EI: PROGRAM_STATUS_WORD[`CTN_PSW_ID] <= 1'b0;
        CTN_K_DI: PROGRAM_STATUS_WORD[`CTN_PSW_ID] <= 1'b1;
        CTN_K_LOAD_SYSREG_INSTR:
          case (INSTR_SREG)
            CTN_S_PSW:   PROGRAM_STATUS_WORD   <= INSTR_WDATA;
            CTN_S_EXCEPTION_SAVED_PC:  EXCEPTION_SAVED_PC  <= INSTR_WDATA;
            CTN_S_EXCEPTION_SAVED_STATUS: EXCEPTION_SAVED_STATUS <= INSTR_WDATA;
            default:     PROGRAM_STATUS_WORD   <= PROGRAM_STATUS_WORD;
          endcase
        default: PROGRAM_STATUS_WORD <= PROGRAM_STATUS_WORD;
      endcase
    end
  end

  // redirect and acknowledge pulses; interrupt vectors are decided downstream by id
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      REDIRECT    <= 1'b0;
      REDIRECT_PC <= 32'h00000000;
      IRQ_ACK     <= 1'b0;
      IRQ_ACK_ID  <= 3'h0;
      NMI_ACK     <= 1'b0;
    end
    else
    begin
      REDIRECT <= dbg_entry || dbg_ret || interrupt_return_instr;
      IRQ_ACK  <= take_irq;
      NMI_ACK  <= take_nmi;
      if (take_irq)
        IRQ_ACK_ID <= sel_idx;
      if (dbg_entry)
        REDIRECT_PC <= `CTN_DBG_VECTOR;
      else if (dbg_ret)
        REDIRECT_PC <= DEBUG_SAVED_PC;
      else if (interrupt_return_instr)
        REDIRECT_PC <= EXCEPTION_SAVED_PC;
    end
  end

  // registered copy of the next monitor state, so the pin comes straight from a flop
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      DEBUG_MODE <= 1'b0;
    else
      DEBUG_MODE <= (mode == CTN_RUN) ? dbg_entry : !dbg_ret;
  end

  // helper for the gap check: a blocking retire opens it, the next retire closes it
  logic gap_open;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      gap_open <= 1'b0;
    else if (INSTR_VALID)
      gap_open <= is_blocking(INSTR_KIND, INSTR_SREG);
  end

  // ********************************************************
  // assertions
  // ********************************************************

  sequence s_trap_seen;
    INSTR_VALID && INSTR_KIND == CTN_K_OTHER && is_illegal(INSTR_WORD);
  endsequence

  sequence s_block_retire;
    INSTR_VALID && is_blocking(INSTR_KIND, INSTR_SREG);
  endsequence

  // idle gaps of any length are bridged by the helper flop, not by a repetition
  sequence s_block_pair;
    gap_open && INSTR_VALID;
  endsequence

  a_trap_vector: assert property (@(posedge CLK) disable iff (RST)
    s_trap_seen |=> REDIRECT && REDIRECT_PC == `CTN_DBG_VECTOR && DEBUG_MODE)
    else $error("opcode trap did not vector to the debug handler");

  a_dbg_save: assert property (@(posedge CLK) disable iff (RST)
    dbg_entry |=> DEBUG_SAVED_PC == $past(RET_PC) && DEBUG_SAVED_STATUS == $past(PROGRAM_STATUS_WORD))
    else $error("debug copies not saved on trap entry");

  a_entry_flags: assert property (@(posedge CLK) disable iff (RST)
    dbg_entry |=> PROGRAM_STATUS_WORD[`CTN_PSW_NP] && PROGRAM_STATUS_WORD[`CTN_PSW_EP] && PROGRAM_STATUS_WORD[`CTN_PSW_ID])
    else $error("status flags not set on trap entry");

  a_dbg_restore: assert property (@(posedge CLK) disable iff (RST)
    dbg_ret |=> PROGRAM_STATUS_WORD == $past(DEBUG_SAVED_STATUS) && REDIRECT && REDIRECT_PC == $past(DEBUG_SAVED_PC) && !DEBUG_MODE)
    else $error("debug return did not restore state");

  a_interrupt_return_instr_restore: assert property (@(posedge CLK) disable iff (RST)
    interrupt_return_instr && !dbg_entry |=> PROGRAM_STATUS_WORD == $past(EXCEPTION_SAVED_STATUS) && REDIRECT_PC == $past(EXCEPTION_SAVED_PC))
    else $error("interrupt return did not restore exception copies");

  a_ack_enabled: assert property (@(posedge CLK) disable iff (RST)
    IRQ_ACK |-> !$past(PROGRAM_STATUS_WORD[`CTN_PSW_ID]) && !$past(PROGRAM_STATUS_WORD[`CTN_PSW_NP]) && PROGRAM_STATUS_WORD[`CTN_PSW_ID])
    else $error("maskable request accepted while held off");

  a_ack_higher: assert property (@(posedge CLK) disable iff (RST)
    IRQ_ACK |-> ($past(IN_SERVICE_PRIORITY_REG) & ~(8'hfe << ack_lvl)) == 8'h00 && IN_SERVICE_PRIORITY_REG[ack_lvl])
    else $error("accepted request did not outrank the one in service");

  a_block_window: assert property (@(posedge CLK) disable iff (RST)
    s_block_pair |=> !IRQ_ACK && !NMI_ACK)
    else $error("interrupt accepted inside a sampling gap");

  a_block_first: assert property (@(posedge CLK) disable iff (RST)
    s_block_retire |=> !IRQ_ACK && !NMI_ACK)
    else $error("interrupt accepted on a sampling-blocking retire");

endmodule
`default_nettype wire

/* File: rtl/ctn_regs.svh */
// constants for the trap and nesting controller
`ifndef CTN_REGS_SVH
`define CTN_REGS_SVH

// status word bit positions
`define CTN_PSW_ID        5
`define CTN_PSW_EP        6
`define CTN_PSW_NP        7
// status word after reset: maskable acceptance held off
`define CTN_PSW_RESET     32'h00000020
// vector shared by the opcode trap and the debug trap
`define CTN_DBG_VECTOR    32'h00000060
// illegal opcode pattern
`define CTN_ILG_OPC       6'h3f
`define CTN_ILG_SUB_MIN   4'h7
// per-source control entry: [2:0] level, [3] mask
`define CTN_CTL_MASK      3
`define CTN_PRIO_LOWEST   3'h7
`define CTN_CTL_RESET     4'hf
`define CTN_NUM_SRC       8
`define CTN_NO_LEVEL      4'h8

`endif

/* File: rtl/ctn_pkg.sv */
// types shared by the trap and nesting controller
package ctn_pkg;

  // class of the instruction leaving the pipeline
  typedef enum logic [3:0] {
    CTN_K_OTHER, CTN_K_DEBUG_TRAP_INSTRUCTION, CTN_K_DEBUG_RETURN_INSTR, CTN_K_INTERRUPT_RETURN_INSTR, CTN_K_EI, CTN_K_DI,
    CTN_K_LOAD_SYSREG_INSTR, CTN_K_IRQREG, CTN_K_PROTECT_COMMAND_REG, CTN_K_SERIAL
  } ctn_kind_t;

  // system register written by a load-sysreg instruction
  typedef enum logic [1:0] {CTN_S_PSW, CTN_S_EXCEPTION_SAVED_PC, CTN_S_EXCEPTION_SAVED_STATUS, CTN_S_NONE} ctn_sreg_t;

  // run or debug monitor
  typedef enum logic {CTN_RUN, CTN_DEBUG} ctn_mode_t;

endpackage

/* File: rtl/ctn_ctrl_mem.sv */
// per-source interrupt control entries (level and mask)
`timescale 1ns/1ps
`default_nettype none
`include "ctn_regs.svh"

module ctn_ctrl_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [2:0]  idx,
  input  wire logic [3:0]  wdata,
  output logic      [3:0]  rdata,
  // all entries for the arbiter
  output logic      [31:0] entries
);

  logic [3:0] mem [`CTN_NUM_SRC];

  // every source masked at lowest level out of reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `CTN_NUM_SRC; i++)
        mem[i] <= `CTN_CTL_RESET;
    end
    else if (wr)
      mem[idx] <= wdata; // 3-bit level field, 0 highest
  end

  // registered read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 4'h0;
    else if (rd)
      rdata <= mem[idx];
  end

  // flat view for parallel arbitration
  always_comb
  begin
    for (int i = 0; i < `CTN_NUM_SRC; i++)
      entries[i*4 +: 4] = mem[i];
  end

endmodule
`default_nettype wire

/* File: verification/ctn_pipe_model.sv */
// pipeline and request source model facing the trap controller
`timescale 1ns/1ps
`default_nettype none
module ctn_pipe_model (
  // clock
  input  wire logic               clk,
  // retire group
  output logic                    instr_valid,
  output logic [31:0]             instr_word,
  output var ctn_pkg::ctn_kind_t  instr_kind,
  output var ctn_pkg::ctn_sreg_t  instr_sreg,
  output logic [31:0]             instr_wdata,
  output logic [31:0]             ret_pc,
  // request sources
  output logic [7:0]              irq_req,
  output logic                    nmi_req
);
  import ctn_pkg::*;
  // **********
  // retire and request drivers
  // **********
  // nothing retires or requests until the bench asks
  initial
  begin
    instr_valid = 1'b0;
    instr_word  = 32'h0;
    instr_kind  = CTN_K_OTHER;
    instr_sreg  = CTN_S_NONE;
    instr_wdata = 32'h0;
    ret_pc      = 32'h0;
    irq_req     = 8'h00;
    nmi_req     = 1'b0;
  end
  // one retire held for one edge; payload inverted after so a stale word cannot pass
  task automatic retire(input ctn_kind_t k, input logic [31:0] w, input ctn_sreg_t s,
                        input logic [31:0] d, input logic [31:0] pc);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    instr_kind  <= k;
    instr_sreg  <= s;
    instr_wdata <= d;
    ret_pc      <= pc;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
    instr_wdata <= ~d;
    ret_pc      <= ~pc;
    #1;
  endtask
  // one-cycle request pulse; the controller keeps it pending
  task automatic raise(input logic [7:0] m, input logic n);
    @(posedge clk);
    irq_req <= m;
    nmi_req <= n;
    @(posedge clk);
    irq_req <= 8'h00;
    nmi_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/cpu_trap_and_nesting_control_bench.sv */
// self-checking bench for the trap and nesting controller
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_and_nesting_control_bench;
  import ctn_pkg::*;
  // **********
  // harness
  // **********
  logic        clk, rst, iv, nmi, cwr, crd, redir, iack, nack, dbg;
  logic [31:0] iw, iwd, ipc, rdpc, st, dpc, dst, xpc, xst;
  logic [7:0]  irq, svc;
  logic [3:0]  cwd, crdat;
  logic [2:0]  cidx, iid;
  ctn_kind_t   ik;
  ctn_sreg_t   isr;
  int          fails = 0;
  int          compares = 0;

  ctn_pipe_model p_u (.clk(clk), .instr_valid(iv), .instr_word(iw), .instr_kind(ik), .instr_sreg(isr),
    .instr_wdata(iwd), .ret_pc(ipc), .irq_req(irq), .nmi_req(nmi));
  ctn_trap_ctrl dut_u (.CLK(clk), .RST(rst), .INSTR_VALID(iv), .INSTR_WORD(iw), .INSTR_KIND(ik),
    .INSTR_SREG(isr), .INSTR_WDATA(iwd), .RET_PC(ipc), .IRQ_REQ(irq), .NMI_REQ(nmi), .CTRL_WR(cwr),
    .CTRL_RD(crd), .CTRL_IDX(cidx), .CTRL_WDATA(cwd), .CTRL_RDATA(crdat), .REDIRECT(redir),
    .REDIRECT_PC(rdpc), .IRQ_ACK(iack), .IRQ_ACK_ID(iid), .NMI_ACK(nack), .PROGRAM_STATUS_WORD(st), .DEBUG_SAVED_PC(dpc),
    .DEBUG_SAVED_STATUS(dst), .EXCEPTION_SAVED_PC(xpc), .EXCEPTION_SAVED_STATUS(xst), .IN_SERVICE_PRIORITY_REG(svc), .DEBUG_MODE(dbg));

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // control entry write and checked read-back
  task automatic cset(input logic [2:0] i, input logic [3:0] d);
    @(posedge clk);
    cwr  <= 1'b1;
    cidx <= i;
    cwd  <= d;
    @(posedge clk);
    cwr <= 1'b0;
  endtask
  task automatic cget(input logic [2:0] i, input logic [3:0] exp);
    @(posedge clk);
    crd  <= 1'b1;
    cidx <= i;
    @(posedge clk);
    crd <= 1'b0;
    #1;
    chk(crdat, exp);
  endtask

  // plain retire of one kind, then judge acceptance and the winning source
  task automatic go(input ctn_kind_t k, input logic [31:0] pc, input logic e, input logic [2:0] id);
    p_u.retire(k, 32'h0, CTN_S_NONE, 32'h0, pc);
    chk(iack, e);
    if (e)
      chk(iid, id);
  endtask
  task automatic ld(input ctn_sreg_t s, input logic [31:0] d);
    p_u.retire(CTN_K_LOAD_SYSREG_INSTR, 32'h0, s, d, 32'h0);
    chk(iack, 1'b0);
  endtask
  task automatic back(input logic [31:0] pc, input logic [31:0] s, input logic [7:0] v);
    p_u.retire(CTN_K_INTERRUPT_RETURN_INSTR, 32'h0, CTN_S_NONE, 32'h0, 32'h0);
    chk(redir, 1'b1);
    chk(rdpc, pc);
    chk(st, s);
    chk(svc, v);
  endtask
  // trap entry then the debug return, both judged
  task automatic trap_back(input ctn_kind_t k, input logic [31:0] w, input logic [31:0] pc);
    logic [31:0] s0;
    s0 = st;
    p_u.retire(k, w, CTN_S_NONE, 32'h0, pc);
    chk(redir, 1'b1);
    chk(rdpc, 32'h60);
    chk(dpc, pc);
    chk(dst, s0);
    chk(st, s0 | 32'he0);
    chk(dbg, 1'b1);
    p_u.retire(CTN_K_DEBUG_RETURN_INSTR, 32'h0, CTN_S_NONE, 32'h0, 32'h0);
    chk(rdpc, pc);
    chk(st, s0);
    chk(dbg, 1'b0);
  endtask

  task automatic t_reset;
    chk(st, 32'h20);
    for (int i = 0; i < 8; i++)
    begin
      cget(i[2:0], 4'hf);
      cset(i[2:0], {1'b1, i[2:0]});
      cget(i[2:0], {1'b1, i[2:0]});
    end
  endtask

  task automatic t_trap;
    logic [31:0] w [3];
    w = '{32'h030007e0, 32'h038107e0, 32'h038007c0};
    foreach (w[i])
    begin
      p_u.retire(CTN_K_OTHER, w[i], CTN_S_NONE, 32'h0, 32'h0);
      chk(redir, 1'b0);
    end
    trap_back(CTN_K_OTHER, 32'h038007e0, 32'h100);
    trap_back(CTN_K_OTHER, 32'h078007e0, 32'h104);
    go(CTN_K_DI, 32'h0, 1'b0, 3'h0);
    trap_back(CTN_K_DEBUG_TRAP_INSTRUCTION, 32'h0, 32'h108);
  endtask

  // nesting: block flag, preemption, held lower level, restore of saved copies
  task automatic t_nest;
    cset(3'h3, 4'h2);
    cset(3'h1, 4'h0);
    cset(3'h5, 4'h4);
    p_u.raise(8'h08, 1'b0);
    go(CTN_K_OTHER, 32'h200, 1'b0, 3'h0);
    ld(CTN_S_PSW, 32'h0);
    go(CTN_K_OTHER, 32'h204, 1'b0, 3'h0);
    go(CTN_K_OTHER, 32'h208, 1'b1, 3'h3);
    chk(svc, 8'h04);
    chk(xpc, 32'h208);
    chk(st, 32'h60);
    p_u.raise(8'h22, 1'b0);
    go(CTN_K_OTHER, 32'h20c, 1'b0, 3'h0);
    ld(CTN_S_PSW, 32'h1);
    go(CTN_K_OTHER, 32'h210, 1'b0, 3'h0);
    go(CTN_K_OTHER, 32'h214, 1'b1, 3'h1);
    chk(svc, 8'h05);
    chk(xst, 32'h1);
    back(32'h214, 32'h1, 8'h04);
    go(CTN_K_OTHER, 32'h218, 1'b0, 3'h0);
    ld(CTN_S_EXCEPTION_SAVED_PC, 32'h208);
    ld(CTN_S_EXCEPTION_SAVED_STATUS, 32'h0);
    back(32'h208, 32'h0, 8'h00);
    go(CTN_K_OTHER, 32'h21c, 1'b1, 3'h5);
    back(32'h21c, 32'h0, 8'h00);
  endtask

  // the EI, IRQREG, protect-command and serial kinds each hold the request off for two retires (DI and psw load not driven)
  task automatic t_block;
    ctn_kind_t ks [4];
    ks = '{CTN_K_EI, CTN_K_IRQREG, CTN_K_PROTECT_COMMAND_REG, CTN_K_SERIAL};
    foreach (ks[i])
    begin
      p_u.raise(8'h08, 1'b0);
      go(ks[i], 32'h300, 1'b0, 3'h0);
      go(CTN_K_OTHER, 32'h304, 1'b0, 3'h0);
      go(CTN_K_OTHER, 32'h308, 1'b1, 3'h3);
      back(32'h308, 32'h0, 8'h00);
    end
  endtask

  task automatic t_nmi;
    p_u.raise(8'h00, 1'b1);
    p_u.retire(CTN_K_OTHER, 32'h0, CTN_S_NONE, 32'h0, 32'h400);
    chk(nack, 1'b1);
    chk(st[7:5], 3'h7);
    p_u.raise(8'h02, 1'b0);
    ld(CTN_S_PSW, 32'h80);
    go(CTN_K_OTHER, 32'h404, 1'b0, 3'h0);
    go(CTN_K_OTHER, 32'h408, 1'b0, 3'h0);
    back(32'h400, 32'h0, 8'h00);
    go(CTN_K_OTHER, 32'h40c, 1'b1, 3'h1);
    back(32'h40c, 32'h0, 8'h00);
  endtask

  // equal levels with a masked level-0 source also raised
  task automatic t_tie;
    cset(3'h4, 4'h1);
    cset(3'h6, 4'h1);
    p_u.raise(8'h51, 1'b0);
    go(CTN_K_OTHER, 32'h500, 1'b1, 3'h4);
    back(32'h500, 32'h0, 8'h00);
    go(CTN_K_OTHER, 32'h504, 1'b1, 3'h6);
    back(32'h504, 32'h0, 8'h00);
  endtask

  initial
  begin
    rst  = 1'b1;
    cwr  = 1'b0;
    crd  = 1'b0;
    cidx = 3'h0;
    cwd  = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_trap;
    t_nest;
    t_block;
    t_nmi;
    t_tie;
    report_and_stop;
  end

  // watchdog: the sequence needs under two hundred cycles, this allows 5000
  initial
  begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
